/* src/edc_ctrl.sv */
// Controller that drives an asynchronous extended-data-out page-mode DRAM
`timescale 1ns/1ps
// How it works
// - After power-up wait 200 us, then run eight refreshes before any access.
// - If refresh falls overdue, rerun the eight-refresh wake-up first.
// - Both strobes go high for precharge before each new cycle.
// - Write strobe stays high until column and row strobes rise in reads.
// - Output enable is never tied low; writes here are early writes.
// - In these early writes, the column strobe falling edge with write strobe low is the write command.
// - Output enable stays high during any write.
// - Write data is set before the column strobe falls in early writes.
// - Page-style column cycles keep at least the page cycle time.
// - Refreshes are issued with write strobe high and output enable high.
// - Issue 1024 refreshes every 16 ms.
module edc_ctrl #(
    parameter int WAKE_CYCLES = edc_pkg::WAKE_CYC,
    parameter int REF_CYCLES = edc_pkg::REF_INT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [19:0] req_addr,
    input wire logic [1:0] req_lanes,
    input wire logic [15:0] req_wdata,
    input wire logic refresh_late,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic init_done,
    output logic row_strobe_n,
    output logic low_byte_column_strobe_n,
    output logic high_byte_column_strobe_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [9:0] dram_addr,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic [15:0] dq_in
);
    typedef enum logic [3:0] {
        ST_WAKE, ST_IDLE, ST_PRE, ST_ROW, ST_COL, ST_HOLD,
        ST_RCAS, ST_RRAS, ST_RDONE
    } edc_state_t;

    typedef struct packed {
        edc_state_t st;
        logic [3:0] ph;
        logic [3:0] ref_left;
        logic ref_due;
        logic is_ref;
        logic wr;
        logic [1:0] lanes;
        logic [9:0] col;
        logic req_ready;
        logic rsp_valid;
        logic [15:0] rdata;
        logic init_done;
        logic ras_n;
        logic started;
        logic col_lo_n;
        logic col_hi_n;
        logic we_n;
        logic oe_n;
        logic [9:0] addr;
        logic [15:0] dq;
        logic dq_oe_n;
    } edc_ctl_t;

    edc_ctl_t s_reg;
    edc_ctl_t s_next;
    logic wake_load;
    logic wake_done;
    logic ref_tick;
    logic ref_load;

    edc_timer u_wake (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(wake_load),
        .value(edc_pkg::CNT_W'(WAKE_CYCLES)),
        .done(wake_done)
    );

    edc_timer u_ref (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(ref_load),
        // Reload on the done cycle adds one, so load one less
        .value(edc_pkg::CNT_W'(REF_CYCLES - 1)),
        .done(ref_tick)
    );

    // Timers start one cycle after reset release
    assign wake_load = !s_reg.started || (refresh_late && s_reg.init_done);
    assign ref_load = !s_reg.started || ref_tick;

    always_comb begin
        s_next = s_reg;
        s_next.started = 1'b1;
        s_next.rsp_valid = 1'b0;
        s_next.req_ready = 1'b0;
        if (ref_tick) begin
            s_next.ref_due = 1'b1;
        end
        if (refresh_late && s_reg.init_done) begin
            // Cut any cycle in flight; strobes rest high for the pause
            s_next.init_done = 1'b0;
            s_next.ref_left = 4'(edc_pkg::WAKE_REFRESHES);
            s_next.ras_n = 1'b1;
            s_next.col_lo_n = 1'b1;
            s_next.col_hi_n = 1'b1;
            s_next.we_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.dq_oe_n = 1'b1;
            s_next.st = ST_WAKE;
        end else begin
            case (s_reg.st)
                ST_WAKE: begin
                    if (wake_done) begin
                        s_next.ref_left = 4'(edc_pkg::WAKE_REFRESHES);
                        s_next.ref_due = 1'b1;
                        s_next.st = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // A request shown ready is taken before a due refresh
                    if (req_valid && s_reg.req_ready) begin
                        s_next.is_ref = 1'b0;
                        s_next.wr = req_write;
                        s_next.lanes = req_lanes;
                        s_next.col = req_addr[9:0];
                        s_next.addr = req_addr[19:10];
                        s_next.dq = req_wdata;
                        s_next.ph = 4'(edc_pkg::ROW_PRE_CYC);
                        s_next.st = ST_PRE;
                    end else if (s_reg.ref_due || s_reg.ref_left != 4'h0) begin
                        s_next.is_ref = 1'b1;
                        s_next.ref_due = ref_tick;
                        s_next.ph = 4'(edc_pkg::ROW_PRE_CYC);
                        s_next.st = ST_PRE;
                    end else if (s_reg.init_done) begin
                        s_next.req_ready = 1'b1;
                    end
                end
                ST_PRE: begin
                    // All strobes high: outputs clear and float
                    s_next.ras_n = 1'b1;
                    s_next.col_lo_n = 1'b1;
                    s_next.col_hi_n = 1'b1;
                    s_next.we_n = 1'b1;
                    s_next.oe_n = 1'b1;
                    s_next.dq_oe_n = 1'b1;
                    s_next.ph = s_reg.ph - 1'b1;
                    if (s_reg.ph <= 4'h1) begin
                        s_next.ph = 4'(edc_pkg::ROW_TO_COL_CYC);
                        if (s_reg.is_ref) begin
                            // Column strobes before row strobe
                            s_next.col_lo_n = 1'b0;
                            s_next.col_hi_n = 1'b0;
                            s_next.st = ST_ROW;
                        end else begin
                            s_next.ras_n = 1'b0;
                            s_next.st = ST_ROW;
                        end
                    end
                end
                ST_ROW: begin
                    s_next.ph = s_reg.ph - 1'b1;
                    if (s_reg.is_ref) begin
                        s_next.ras_n = 1'b0;
                        s_next.ph = 4'(edc_pkg::ROW_PULSE_CYC);
                        s_next.st = ST_HOLD;
                    end else if (s_reg.ph <= 4'h1) begin
                        s_next.addr = s_reg.col;
                        if (s_reg.wr) begin
                            s_next.we_n = 1'b0;
                            s_next.dq_oe_n = 1'b0;
                        end else begin
                            s_next.oe_n = 1'b0;
                        end
                        s_next.st = ST_COL;
                    end
                end
                ST_COL: begin
                    // Column strobes per lane, address already stable
                    s_next.col_lo_n = !s_reg.lanes[0];
                    s_next.col_hi_n = !s_reg.lanes[1];
                    s_next.ph = 4'(edc_pkg::COL_PULSE_CYC);
                    s_next.st = ST_HOLD;
                end
                ST_HOLD: begin
                    s_next.ph = s_reg.ph - 1'b1;
                    if (s_reg.ph <= 4'h1) begin
                        if (s_reg.is_ref) begin
                            s_next.st = ST_RRAS;
                        end else begin
                            s_next.st = ST_RCAS;
                        end
                    end
                end
                ST_RCAS: begin
                    // Capture read data while strobes still low
                    if (!s_reg.wr) begin
                        s_next.rdata[7:0] = s_reg.lanes[0] ? dq_in[7:0] : 8'h00;
                        s_next.rdata[15:8] = s_reg.lanes[1] ?
                            dq_in[15:8] : 8'h00;
                    end
                    s_next.oe_n = 1'b1;
                    s_next.col_lo_n = 1'b1;
                    s_next.col_hi_n = 1'b1;
                    s_next.st = ST_RRAS;
                end
                ST_RRAS: begin
                    s_next.ras_n = 1'b1;
                    s_next.col_lo_n = 1'b1;
                    s_next.col_hi_n = 1'b1;
                    s_next.st = ST_RDONE;
                end
                ST_RDONE: begin
                    // Write strobe released only after both strobes
                    s_next.we_n = 1'b1;
                    s_next.dq_oe_n = 1'b1;
                    if (s_reg.is_ref) begin
                        if (s_reg.ref_left != 4'h0) begin
                            s_next.ref_left = s_reg.ref_left - 1'b1;
                            if (s_reg.ref_left == 4'h1) begin
                                s_next.init_done = 1'b1;
                            end
                        end
                    end else begin
                        s_next.rsp_valid = 1'b1;
                    end
                    s_next.st = ST_IDLE;
                end
                default: begin
                    s_next.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.st <= ST_WAKE;
            s_reg.ras_n <= 1'b1;
            s_reg.col_lo_n <= 1'b1;
            s_reg.col_hi_n <= 1'b1;
            s_reg.we_n <= 1'b1;
            s_reg.oe_n <= 1'b1;
            s_reg.dq_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready = s_reg.req_ready;
    assign rsp_valid = s_reg.rsp_valid;
    assign rsp_rdata = s_reg.rdata;
    assign init_done = s_reg.init_done;
    assign row_strobe_n = s_reg.ras_n;
    assign low_byte_column_strobe_n = s_reg.col_lo_n;
    assign high_byte_column_strobe_n = s_reg.col_hi_n;
    assign write_strobe_n = s_reg.we_n;
    assign output_enable_n = s_reg.oe_n;
    assign dram_addr = s_reg.addr;
    assign dq_out = s_reg.dq;
    assign dq_oe_n = s_reg.dq_oe_n;
endmodule

/* src/edc_pkg.sv */
// Package with timing and width constants for the DRAM controller
package edc_pkg;
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 40;
    // Power-up pause in microseconds
    localparam int WAKE_US = 200;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int WAKE_REFRESHES = 8;
    // Refresh period in milliseconds, spread over this many rows
    localparam int REF_PERIOD_MS = 16;
    localparam int REF_ROWS = 1024;
    localparam int REF_INT_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
    // Strobe phase lengths in ns, each rounded up to whole cycles
    localparam int ROW_PRE_NS = 30;
    localparam int ROW_PRE_CYC = (ROW_PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_TO_COL_NS = 20;
    localparam int ROW_TO_COL_CYC = (ROW_TO_COL_NS + CLK_NS - 1) / CLK_NS;
    localparam int COL_PULSE_NS = 14;
    localparam int COL_PULSE_CYC = (COL_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_PULSE_NS = 50;
    localparam int ROW_PULSE_CYC = (ROW_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
endpackage

/* src/edc_timer.sv */
// Down counter that pulses when a loaded count expires
`timescale 1ns/1ps
module edc_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [edc_pkg::CNT_W-1:0] value,
    output logic done
);
    typedef struct packed {
        logic [edc_pkg::CNT_W-1:0] cnt;
        logic done;
    } edc_tmr_t;
    edc_tmr_t s_reg;
    edc_tmr_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (load) begin
            s_next.cnt = value;
        end else if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
            if (s_reg.cnt == 16'h0001) begin
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
endmodule

/* testbench/edc_ctrl_assertions.sv */
// Port assertions for the page-mode DRAM controller
`timescale 1ns/1ps
module edc_ctrl_assertions #(
    parameter int WAKE_CYCLES = 20,
    parameter int REF_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [19:0] req_addr,
    input wire logic init_done,
    input wire logic row_strobe_n,
    input wire logic low_byte_column_strobe_n,
    input wire logic high_byte_column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [9:0] dram_addr,
    input wire logic dq_oe_n
);
    wire [1:0] cs = {high_byte_column_strobe_n, low_byte_column_strobe_n};
    logic ras_reg;
    wire order_go = ras_reg && !row_strobe_n && cs != 2'b11;
    int up_cnt;
    int gap_cnt;
    int order_cnt;
    logic [19:0] addr_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ras_reg <= 1'b1;
            up_cnt <= 0;
            gap_cnt <= 0;
            order_cnt <= 0;
        end else begin
            ras_reg <= row_strobe_n;
            up_cnt <= (up_cnt < WAKE_CYCLES) ? up_cnt + 1 : up_cnt;
            gap_cnt <= order_go ? 0 : gap_cnt + 1;
            order_cnt <= init_done ? 0 : order_cnt + int'(order_go);
        end
        if (req_valid && req_ready) begin
            addr_reg <= req_addr;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wake_pause_a: assert property (
        up_cnt < WAKE_CYCLES |-> row_strobe_n)
        else $error("row strobe active in wake pause");
    wake_count_a: assert property (
        $rose(init_done) |-> order_cnt >= edc_pkg::WAKE_REFRESHES)
        else $error("too few wake refreshes");
    ready_gate_a: assert property (
        req_ready |-> init_done)
        else $error("ready before wake-up");
    row_precharge_a: assert property (
        $fell(row_strobe_n) |-> $past(row_strobe_n, 2))
        else $error("row precharge too short");
    write_oe_a: assert property (
        !write_strobe_n |-> output_enable_n)
        else $error("output enable low in write");
    early_write_a: assert property (
        ($fell(cs[0]) || $fell(cs[1])) && !row_strobe_n && !write_strobe_n
        |-> $past(!write_strobe_n) && !dq_oe_n)
        else $error("write not early");
    read_we_a: assert property (
        !output_enable_n |-> write_strobe_n)
        else $error("write strobe low in read");
    order_refresh_a: assert property (
        order_go
        |-> write_strobe_n && output_enable_n && $past(cs) == 2'b00)
        else $error("bad strobe-order refresh");
    row_addr_a: assert property (
        $fell(row_strobe_n) && cs == 2'b11
        |-> dram_addr == addr_reg[19:10])
        else $error("row address wrong");
    col_addr_a: assert property (
        ($fell(cs[0]) || $fell(cs[1])) && !row_strobe_n
        |-> dram_addr == addr_reg[9:0])
        else $error("column address wrong");
    ref_gap_a: assert property (
        init_done |-> gap_cnt <= REF_CYCLES + 16)
        else $error("refresh overdue");
    cover property ($rose(init_done));
    cover property (order_go);
    cover property (!write_strobe_n && !cs[0]);
    cover property (!output_enable_n && !cs[1]);
endmodule

bind edc_ctrl edc_ctrl_assertions #(.WAKE_CYCLES(WAKE_CYCLES),
    .REF_CYCLES(REF_CYCLES)) chk (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .init_done(init_done), .row_strobe_n(row_strobe_n),
    .low_byte_column_strobe_n(low_byte_column_strobe_n),
    .high_byte_column_strobe_n(high_byte_column_strobe_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .dram_addr(dram_addr), .dq_oe_n(dq_oe_n));

/* testbench/edc_ctrl_bench.sv */
// Self-checking bench for the page-mode DRAM controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module edc_ctrl_bench;
    localparam int WAKE = 20;
    localparam int REFC = 50;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [1:0] req_lanes = 2'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic refresh_late = 1'b0;
    logic req_ready, rsp_valid, init_done, row_n, lo_n, hi_n, we_n, oe_n;
    logic dq_oe_n;
    logic [15:0] rsp_rdata, dq_out, dq_in;
    logic [9:0] dram_addr;
    int bad_count = 0;
    int checks_done = 0;
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    edc_ctrl #(.WAKE_CYCLES(WAKE), .REF_CYCLES(REFC)) DUT (
        .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
        .req_wdata(req_wdata), .refresh_late(refresh_late),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .init_done(init_done), .row_strobe_n(row_n),
        .low_byte_column_strobe_n(lo_n), .high_byte_column_strobe_n(hi_n),
        .write_strobe_n(we_n), .output_enable_n(oe_n),
        .dram_addr(dram_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in));
    edc_dram_model mem_model (.row_strobe_n(row_n),
        .low_byte_column_strobe_n(lo_n), .high_byte_column_strobe_n(hi_n),
        .write_strobe_n(we_n), .output_enable_n(oe_n),
        .dram_addr(dram_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (s !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic access(input logic wr, input logic [19:0] a,
        input logic [1:0] ln, input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_lanes = ln;
        req_wdata = wd;
        // Hold the request until ready is seen at an edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        #1;
        req_valid = 1'b0;
        wait_for(rsp_valid, 1'b1, 20, n);
        `CHK("rsp_valid", 1'b1, rsp_valid)
        rd = rsp_rdata;
        tick(1);
    endtask
    task automatic t_wake();
        int n;
        wait_for(init_done, 1'b1, 2000, n);
        `CHK("wake_len", 1'b1, n >= WAKE)
        `CHK("wake_refresh", 1'b1, mem_model.refreshes >= 8)
    endtask
    task automatic t_lanes();
        logic [15:0] rd;
        access(1'b1, 20'h2A155, 2'b11, 16'hA1B2, rd);
        access(1'b1, 20'h2A155, 2'b01, 16'hFFC3, rd);
        access(1'b1, 20'h15155, 2'b11, 16'h5A5A, rd);
        access(1'b0, 20'h2A155, 2'b11, 16'h0000, rd);
        `CHK("word", 16'hA1C3, rd)
        access(1'b0, 20'h2A155, 2'b10, 16'h0000, rd);
        `CHK("high_lane", 16'hA100, rd)
        access(1'b0, 20'h15155, 2'b01, 16'h0000, rd);
        `CHK("low_lane", 16'h005A, rd)
    endtask
    task automatic t_rate();
        int r0;
        r0 = mem_model.refreshes;
        tick(REFC * 10);
        `CHK("refresh_rate", 1'b1, mem_model.refreshes - r0 >= 9)
    endtask
    task automatic t_late();
        int n;
        int r0;
        logic [15:0] rd;
        refresh_late = 1'b1;
        tick(1);
        refresh_late = 1'b0;
        wait_for(init_done, 1'b0, 20, n);
        `CHK("init_drop", 1'b0, init_done)
        r0 = mem_model.refreshes;
        wait_for(init_done, 1'b1, 2000, n);
        `CHK("rewake", 1'b1, mem_model.refreshes - r0 >= 8)
        access(1'b0, 20'h2A155, 2'b11, 16'h0000, rd);
        `CHK("after_rewake", 16'hA1C3, rd)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(8);
        rst = 1'b0;
        t_wake();
        t_lanes();
        t_rate();
        t_late();
        complete_run();
    end
    initial begin
        tick(20000);
        bad_count++;
        complete_run();
    end
endmodule

/* testbench/edc_dram_model.sv */
// Behavioural model of the extended-data-out page-mode DRAM
`timescale 1ns/1ps
module edc_dram_model (
    input wire logic row_strobe_n,
    input wire logic low_byte_column_strobe_n,
    input wire logic high_byte_column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [9:0] dram_addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    output logic [15:0] dq_in
);
    logic [15:0] mem [int];
    logic [15:0] rd = 16'h0000;
    logic [15:0] tmp;
    logic [19:0] key = 20'h00000;
    logic [9:0] row = 10'h000;
    logic refr = 1'b0;
    logic rdcyc = 1'b0;
    logic lo_dn;
    logic hi_dn;
    int refreshes = 0;
    wire [1:0] cs = {high_byte_column_strobe_n, low_byte_column_strobe_n};
    // Lane drives only in a read with its strobe and enable low
    wire [1:0] drv = {2{rdcyc && !output_enable_n}} & ~cs;
    always @(negedge row_strobe_n) begin
        refr = (cs != 2'b11);
        if (refr) begin
            refreshes++;
        end else begin
            row = dram_addr;
            rdcyc = 1'b0;
        end
    end
    // Ports read directly: the lane wire may still lag in this step
    always @(negedge low_byte_column_strobe_n or
             negedge high_byte_column_strobe_n) begin
        lo_dn = !low_byte_column_strobe_n;
        hi_dn = !high_byte_column_strobe_n;
        if (!row_strobe_n && !refr) begin
            key = {row, dram_addr};
            tmp = mem.exists(key) ? mem[key] : 16'h0000;
            if (!write_strobe_n) begin
                // Early write, outputs stay open
                if (lo_dn) tmp[7:0] = dq_out[7:0];
                if (hi_dn) tmp[15:8] = dq_out[15:8];
                mem[key] = tmp;
                rdcyc = 1'b0;
            end else begin
                rd = tmp;
                rdcyc = 1'b1;
            end
        end
    end
    // Late write: write strobe falls with a column strobe already low
    always @(negedge write_strobe_n) begin
        if (!row_strobe_n && !refr && cs != 2'b11) begin
            if (!cs[0]) rd[7:0] = dq_out[7:0];
            if (!cs[1]) rd[15:8] = dq_out[15:8];
            mem[key] = rd;
        end
    end
    // Released lanes show the inverse of the held data
    assign dq_in = !dq_oe_n ? dq_out :
        {drv[1] ? rd[15:8] : ~rd[15:8], drv[0] ? rd[7:0] : ~rd[7:0]};
endmodule
